// file: hw/comparator_control.sv
// Comparator control, status and input buffer logic on APB
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps

// Overview of operation
// - Power-off bit cuts comparator power; may be set any time
// - Reference select picks internal reference, else positive pin
// - Result passes a synchroniser, one to two cycles delay
// - Flag sets when synchronised result change matches event mode
// - Interrupt requested when flag, enable and global enable all set
// - Flag clears on vector execution or on write of one
// - Capture routing bit connects result to timer capture front end
// - Mode 00 toggle, 01 reserved, 10 falling, 11 rising
// - Hysteresis enable on; level bit picks 20 or 50 mV
// - Bit 4 of register B is read-only zero
// - Negative input from converter mux when selected and converter off; code also requires channel code below 8
// - Set disable bit kills pin input buffer; pin reads zero
// - All control bits reset to zero; result bit also resets to zero in the synchroniser
// - Result is one when positive input exceeds negative input
// - Channel codes 0000 to 0111 route converter pins 0 to 7
module comparator_control
   import comparator_pkg::*;
#(
   parameter int PINS = PIN_COUNT
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              clk_en,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [DATA_W-1:0] pwdata,
   output      logic [DATA_W-1:0] prdata,
   output      logic              pready,
   output      logic              pslverr,
   input  wire logic              compare_raw,
   input  wire logic [PINS-1:0]   pin_raw,
   input  wire logic              converter_enable,
   input  wire logic [CHAN_W-1:0] channel_select,
   input  wire logic              global_irq_enable,
   input  wire logic              irq_vector_ack,
   output      logic              comparator_power_off,
   output      logic              positive_ref_select,
   output      logic              negative_mux_active,
   output      logic [CHAN_IDX_W-1:0] negative_channel,
   output      logic              hysteresis_on,
   output      logic              hysteresis_high,
   output      logic              compare_result_sync,
   output      logic              compare_irq,
   output      logic              capture_route_enable,
   output      logic              capture_trigger,
   output      logic [PINS-1:0]   input_buffer_off,
   output      logic [PINS-1:0]   pin_read
);

   // Address decode shared by read and write paths
   function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
      reg_sel_t s;
      s = SEL_NONE;
      if (a == ADDR_INPUT_DISABLE) begin
         s = SEL_DISABLE;
      end else if (a == ADDR_CTRL_B) begin
         s = SEL_CTRL_B;
      end else if (a == ADDR_CTRL_A) begin
         s = SEL_CTRL_A;
      end
      return s;
   endfunction

   // Bus state
   logic [DATA_W-1:0] prdata_q;
   logic              pready_q;
   logic              pslverr_q;
   reg_sel_t          sel;
   logic              setup;
   logic              wr_en;
   logic [BYTE_W-1:0] wbyte;
   logic [BYTE_W-1:0] rbyte;

   // Register A fields
   logic              power_off_q;
   logic              ref_sel_q;
   logic              flag_q;
   logic              flag_d;
   logic              irq_en_q;
   logic              route_q;
   event_mode_t       mode_q;

   // Register B fields
   logic              hyst_en_q;
   logic              hyst_lvl_q;
   logic              neg_sel_q;
   logic [3:0]        touch_q;

   // Input disable register
   logic [PINS-1:0]   disable_q;

   // Result path
   logic              result_sync;
   logic              event_hit;
   logic              flag_clear;
   logic [PINS-1:0]   pin_sync;
   logic              mux_code_ok;

   // Registered outputs
   logic              irq_q;
   logic              trigger_q;
   logic              mux_active_q;
   logic [CHAN_IDX_W-1:0] channel_q;
   logic              hyst_high_q;
   logic [PINS-1:0]   pin_read_q;

   // Comparator result synchroniser
   sync2 #(
      .WIDTH (1)
   ) u_result_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .en    (clk_en),
      .d     (compare_raw),
      .q     (result_sync)
   );

   // Pin level synchroniser
   sync2 #(
      .WIDTH (PINS)
   ) u_pin_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .en    (clk_en),
      .d     (pin_raw),
      .q     (pin_sync)
   );

   // Result event detector
   edge_event u_event (
      .clk   (pclk),
      .rst_n (presetn),
      .en    (clk_en),
      .level (result_sync),
      .mode  (mode_q),
      .hit   (event_hit)
   );

   // Bus decode
   assign sel   = decode(paddr);
   assign setup = psel & ~penable;
   assign wr_en = psel & penable & pwrite & pready_q & ~pslverr_q;
   assign wbyte = pwdata[BYTE_W-1:0];

   // Read mux
   always_comb begin
      rbyte = RESET_BYTE;
      case (sel)
         SEL_DISABLE: begin
            rbyte = disable_q[BYTE_W-1:0];
         end
         SEL_CTRL_B: begin
            rbyte[B_HYST_EN]  = hyst_en_q;
            rbyte[B_HYST_LVL] = hyst_lvl_q;
            rbyte[B_TOUCH5]   = touch_q[3];
            rbyte[B_ZERO4]    = 1'b0;
            rbyte[B_TOUCH3]   = touch_q[2];
            rbyte[B_NEG_SEL]  = neg_sel_q;
            rbyte[B_TOUCH1]   = touch_q[1];
            rbyte[B_TOUCH0]   = touch_q[0];
         end
         SEL_CTRL_A: begin
            rbyte[A_POWER_OFF] = power_off_q;
            rbyte[A_REF_SEL]   = ref_sel_q;
            rbyte[A_RESULT]    = result_sync;
            rbyte[A_FLAG]      = flag_q;
            rbyte[A_IRQ_EN]    = irq_en_q;
            rbyte[A_ROUTE]     = route_q;
            rbyte[A_MODE_HI]   = mode_q[1];
            rbyte[A_MODE_LO]   = mode_q[0];
         end
         default: begin
            rbyte = RESET_BYTE;
         end
      endcase
   end

   // Ready: one cycle after setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
      end else if (clk_en) begin
         pready_q <= setup;
      end
   end

   // Error for unmapped addresses
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr_q <= 1'b0;
      end else if (clk_en) begin
         pslverr_q <= setup & (sel == SEL_NONE);
      end
   end

   // Read data captured at setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= '0;
      end else if (clk_en) begin
         if (setup && !pwrite) begin
            prdata_q <= {{(DATA_W-BYTE_W){1'b0}}, rbyte};
         end else begin
            prdata_q <= '0;
         end
      end
   end

   // Register A control bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_off_q <= 1'b0;
         ref_sel_q   <= 1'b0;
         irq_en_q    <= 1'b0;
         route_q     <= 1'b0;
         mode_q      <= MODE_TOGGLE;
      end else if (clk_en && wr_en && sel == SEL_CTRL_A) begin
         power_off_q <= wbyte[A_POWER_OFF];
         ref_sel_q   <= wbyte[A_REF_SEL];
         irq_en_q    <= wbyte[A_IRQ_EN];
         route_q     <= wbyte[A_ROUTE];
         mode_q      <= event_mode_t'({wbyte[A_MODE_HI],
                                       wbyte[A_MODE_LO]});
      end
   end

   // Event flag: set wins over clear
   assign flag_clear = irq_vector_ack |
      (wr_en & (sel == SEL_CTRL_A) & wbyte[A_FLAG]);
   assign flag_d = event_hit | (flag_q & ~flag_clear);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q <= 1'b0;
      end else if (clk_en) begin
         flag_q <= flag_d;
      end
   end

   // Register B control bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hyst_en_q  <= 1'b0;
         hyst_lvl_q <= 1'b0;
         neg_sel_q  <= 1'b0;
         touch_q    <= '0;
      end else if (clk_en && wr_en && sel == SEL_CTRL_B) begin
         hyst_en_q  <= wbyte[B_HYST_EN];
         hyst_lvl_q <= wbyte[B_HYST_LVL];
         neg_sel_q  <= wbyte[B_NEG_SEL];
         touch_q    <= {wbyte[B_TOUCH5], wbyte[B_TOUCH3],
                        wbyte[B_TOUCH1], wbyte[B_TOUCH0]};
      end
   end

   // Input buffer disable register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         disable_q <= '0;
      end else if (clk_en && wr_en && sel == SEL_DISABLE) begin
         disable_q <= wbyte[PINS-1:0];
      end
   end

   // Interrupt request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
      end else if (clk_en) begin
         irq_q <= flag_q & irq_en_q & global_irq_enable;
      end
   end

   // Timer capture path
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trigger_q <= 1'b0;
      end else if (clk_en) begin
         trigger_q <= route_q & result_sync;
      end
   end

   // Negative input selection
   assign mux_code_ok = (channel_select < CHAN_W'(PIN_COUNT));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mux_active_q <= 1'b0;
      end else if (clk_en) begin
         mux_active_q <= neg_sel_q & ~converter_enable
                         & mux_code_ok;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         channel_q <= '0;
      end else if (clk_en) begin
         channel_q <= channel_select[CHAN_IDX_W-1:0];
      end
   end

   // Hysteresis level ignored while disabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hyst_high_q <= 1'b0;
      end else if (clk_en && wr_en && sel == SEL_CTRL_B) begin
         hyst_high_q <= wbyte[B_HYST_EN] & wbyte[B_HYST_LVL];
      end
   end

   // Port input reads masked by disables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_read_q <= '0;
      end else if (clk_en) begin
         pin_read_q <= pin_sync & ~disable_q;
      end
   end

   // Output wiring
   assign prdata               = prdata_q;
   assign pready               = pready_q;
   assign pslverr              = pslverr_q;
   assign comparator_power_off = power_off_q;
   assign positive_ref_select  = ref_sel_q;
   assign negative_mux_active  = mux_active_q;
   assign negative_channel     = channel_q;
   assign hysteresis_on        = hyst_en_q;
   assign hysteresis_high      = hyst_high_q;
   assign compare_result_sync  = result_sync;
   assign compare_irq          = irq_q;
   assign capture_route_enable = route_q;
   assign capture_trigger      = trigger_q;
   assign input_buffer_off     = disable_q;
   assign pin_read             = pin_read_q;

endmodule

// file: hw/edge_event.sv
// Edge and toggle event detector on a synchronised level
`timescale 1ns/1ps
module edge_event
   import comparator_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        en,
   input  wire logic        level,
   input  event_mode_t      mode,
   output      logic        hit
);
   logic prev_q;
   logic primed_q;
   logic rise;
   logic fall;

   // Previous value, primed after first sample
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_q   <= 1'b0;
         primed_q <= 1'b0;
      end else if (en) begin
         prev_q   <= level;
         primed_q <= 1'b1;
      end
   end

   assign rise = primed_q & level & ~prev_q;
   assign fall = primed_q & ~level & prev_q;

   always_comb begin
      case (mode)
         MODE_TOGGLE: hit = rise | fall;
         MODE_FALL:   hit = fall;
         MODE_RISE:   hit = rise;
         default:     hit = 1'b0;
      endcase
   end
endmodule

// file: hw/sync2.sv
// Two-flop synchroniser for asynchronous levels
`timescale 1ns/1ps
module sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             en,
   input  wire logic [WIDTH-1:0] d,
   output      logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] stage1_q;
   logic [WIDTH-1:0] stage2_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1_q <= '0;
         stage2_q <= '0;
      end else if (en) begin
         stage1_q <= d;
         stage2_q <= stage1_q;
      end
   end

   assign q = stage2_q;
endmodule

// file: pkg/comparator_pkg.sv
// Shared constants and types for the comparator control block
package comparator_pkg;

   // Bus widths
   localparam int DATA_W    = 32;
   localparam int ADDR_W    = 8;
   localparam int BYTE_W    = 8;
   localparam int WORD_SHIFT = 2;

   // Register indices and their byte addresses
   localparam logic [ADDR_W-1:0] IDX_INPUT_DISABLE = 8'h0d;
   localparam logic [ADDR_W-1:0] IDX_CTRL_B        = 8'h13;
   localparam logic [ADDR_W-1:0] IDX_CTRL_A        = 8'h14;
   localparam logic [ADDR_W-1:0] ADDR_INPUT_DISABLE =
      IDX_INPUT_DISABLE << WORD_SHIFT;
   localparam logic [ADDR_W-1:0] ADDR_CTRL_B = IDX_CTRL_B << WORD_SHIFT;
   localparam logic [ADDR_W-1:0] ADDR_CTRL_A = IDX_CTRL_A << WORD_SHIFT;

   // Control and status register A bit positions
   localparam int A_POWER_OFF = 7;
   localparam int A_REF_SEL   = 6;
   localparam int A_RESULT    = 5;
   localparam int A_FLAG      = 4;
   localparam int A_IRQ_EN    = 3;
   localparam int A_ROUTE     = 2;
   localparam int A_MODE_HI   = 1;
   localparam int A_MODE_LO   = 0;

   // Control register B bit positions
   localparam int B_HYST_EN  = 7;
   localparam int B_HYST_LVL = 6;
   localparam int B_TOUCH5   = 5;
   localparam int B_ZERO4    = 4;
   localparam int B_TOUCH3   = 3;
   localparam int B_NEG_SEL  = 2;
   localparam int B_TOUCH1   = 1;
   localparam int B_TOUCH0   = 0;

   // Reset values
   localparam logic [BYTE_W-1:0] RESET_BYTE = 8'h00;

   // Converter channel select
   localparam int CHAN_W     = 4;
   localparam int CHAN_IDX_W = 3;
   localparam int PIN_COUNT  = 8;

   // Hysteresis levels in millivolts
   localparam int HYST_LOW_MV  = 20;
   localparam int HYST_HIGH_MV = 50;

   typedef enum logic [1:0] {
      MODE_TOGGLE   = 2'b00,
      MODE_RESERVED = 2'b01,
      MODE_FALL     = 2'b10,
      MODE_RISE     = 2'b11
   } event_mode_t;

   typedef enum logic [1:0] {
      SEL_NONE    = 2'b00,
      SEL_DISABLE = 2'b01,
      SEL_CTRL_B  = 2'b10,
      SEL_CTRL_A  = 2'b11
   } reg_sel_t;

endpackage

// file: verif/analog_cpu_model.sv
// Analog comparator and CPU vector fetch model
`timescale 1ns/1ps
module analog_cpu_model #(
   parameter int REF_MV = 1000
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic positive_ref_select,
   input  var  int   pos_mv,
   input  var  int   neg_mv,
   input  wire logic ack_on,
   input  wire logic compare_irq,
   output      logic compare_raw,
   output      logic irq_vector_ack
);
   // Positive side picks reference or pin
   always_comb begin
      compare_raw = (positive_ref_select ? REF_MV : pos_mv)
                    > neg_mv;
   end
   // Vector fetch acknowledges a pending request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) irq_vector_ack <= 1'b0;
      else irq_vector_ack <= compare_irq & ack_on & !irq_vector_ack;
   end
endmodule

// file: verif/comparator_monitor.sv
// Port checker for the comparator control block
`timescale 1ns/1ps
module comparator_monitor
   import comparator_pkg::*;
#(
   parameter int PINS = PIN_COUNT
) (
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              compare_raw,
   input wire logic              converter_enable,
   input wire logic [CHAN_W-1:0] channel_select,
   input wire logic              global_irq_enable,
   input wire logic              negative_mux_active,
   input wire logic [CHAN_IDX_W-1:0] negative_channel,
   input wire logic              hysteresis_on,
   input wire logic              hysteresis_high,
   input wire logic              compare_result_sync,
   input wire logic              compare_irq,
   input wire logic              capture_route_enable,
   input wire logic              capture_trigger,
   input wire logic [PINS-1:0]   input_buffer_off,
   input wire logic [PINS-1:0]   pin_read
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sync_delay_a: assert property ($rose(compare_raw) |->
      ##[1:2] compare_result_sync) else $error("result sync late");
   irq_gate_a: assert property (compare_irq |->
      $past(global_irq_enable)) else $error("irq without global enable");
   capture_path_a: assert property (capture_trigger |->
      $past(capture_route_enable) && $past(compare_result_sync))
      else $error("capture trigger without route");
   hyst_level_a: assert property (hysteresis_high |-> hysteresis_on)
      else $error("hysteresis level while off");
   neg_mux_a: assert property (negative_mux_active |->
      !$past(converter_enable) && $past(channel_select) < 4'h8)
      else $error("mux active with converter on");
   neg_chan_a: assert property (negative_mux_active |->
      {1'b0, negative_channel} == $past(channel_select))
      else $error("wrong negative channel");
   pin_mask_a: assert property (
      (pin_read & $past(input_buffer_off)) == '0)
      else $error("disabled pin reads one");
   ready_pulse_a: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("ready not one cycle");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   cover property ($rose(compare_irq));
   cover property ($rose(capture_trigger));
   cover property ($rose(negative_mux_active));
endmodule

bind comparator_control comparator_monitor #(.PINS(PINS)) u_mon (
   .pclk, .presetn, .psel, .penable, .pready, .pslverr, .compare_raw,
   .converter_enable, .channel_select, .global_irq_enable,
   .negative_mux_active, .negative_channel, .hysteresis_on,
   .hysteresis_high, .compare_result_sync, .compare_irq,
   .capture_route_enable, .capture_trigger, .input_buffer_off, .pin_read
);

// file: verif/tb_top.sv
// Testbench for the comparator control block
`timescale 1ns/1ps
module tb_top
   import comparator_pkg::*;
;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic ack_on = 0, conv = 0, gie = 0, clk_en = 1, err;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0, prdata;
   logic [CHAN_W-1:0] chan = '0;
   logic [PIN_COUNT-1:0] pins = '0, buf_off, pin_rd;
   logic [CHAN_IDX_W-1:0] neg_ch;
   logic [BYTE_W-1:0] rd;
   logic pready, pslverr, raw, ack, pwr_off, ref_sel, mux_act;
   logic hy_on, hy_hi, res, irq, route, trig;
   int pos_mv = 0, neg_mv = 100, n_mismatch = 0, checks = 0;
   always #50 pclk = ~pclk;
   comparator_control u_dut (.pclk, .presetn, .clk_en, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .compare_raw(raw), .pin_raw(pins), .converter_enable(conv),
      .channel_select(chan), .global_irq_enable(gie), .irq_vector_ack(ack),
      .comparator_power_off(pwr_off), .positive_ref_select(ref_sel),
      .negative_mux_active(mux_act), .negative_channel(neg_ch),
      .hysteresis_on(hy_on), .hysteresis_high(hy_hi),
      .compare_result_sync(res), .compare_irq(irq),
      .capture_route_enable(route), .capture_trigger(trig),
      .input_buffer_off(buf_off), .pin_read(pin_rd));
   analog_cpu_model u_model (.pclk, .presetn, .positive_ref_select(ref_sel),
      .pos_mv, .neg_mv, .ack_on, .compare_irq(irq), .compare_raw(raw),
      .irq_vector_ack(ack));
   task stop_test;
      if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task cmp8(string n, logic [7:0] e, logic [7:0] g);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask
   task cmp1(string n, logic e, logic g);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s exp %b got %b", n, e, g);
      end
   endtask
   task settle(int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask
   task apb(logic w, logic [ADDR_W-1:0] a, logic [BYTE_W-1:0] d);
      int i;
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {{(DATA_W-BYTE_W){1'b0}}, d};
      @(posedge pclk);
      penable <= 1;
      i = 0;
      #1;
      while (pready !== 1'b1 && i < 20) begin
         @(posedge pclk);
         #1;
         i++;
      end
      if (i >= 20) begin
         n_mismatch++;
         stop_test();
      end
      rd = prdata[BYTE_W-1:0];
      err = pslverr;
      @(posedge pclk);
      psel <= 0;
      penable <= 0;
   endtask
   task wr(logic [ADDR_W-1:0] a, logic [BYTE_W-1:0] d);
      apb(1, a, d);
   endtask
   task rdc(logic [ADDR_W-1:0] a, logic [BYTE_W-1:0] e, string n);
      apb(0, a, 8'h00);
      cmp8(n, e, rd);
   endtask
   task drive_pos(int v);
      @(posedge pclk);
      pos_mv <= v;
      settle(5);
   endtask
   task t_reset;
      rdc(ADDR_CTRL_A, 8'h00, "reg a");
      rdc(ADDR_CTRL_B, 8'h00, "reg b");
      rdc(ADDR_INPUT_DISABLE, 8'h00, "disable");
      rdc(8'h00, 8'h00, "unmapped");
      cmp1("unmapped err", 1, err);
   endtask
   task t_ctrl;
      wr(ADDR_CTRL_A, 8'hC0);
      settle(4);
      cmp1("power off", 1, pwr_off);
      cmp1("ref select", 1, ref_sel);
      rdc(ADDR_CTRL_A, 8'hF0, "toggle flag");
      wr(ADDR_CTRL_A, 8'h50);
      rdc(ADDR_CTRL_A, 8'h60, "flag clear");
      wr(ADDR_CTRL_B, 8'hD4);
      rdc(ADDR_CTRL_B, 8'hC4, "reg b ro");
      cmp1("hyst on", 1, hy_on);
      cmp1("hyst 50", 1, hy_hi);
      wr(ADDR_CTRL_B, 8'h44);
      settle(1);
      cmp1("hyst off", 0, hy_on);
      cmp1("hyst lvl", 0, hy_hi);
   endtask
   task t_modes;
      logic [7:0] m;
      wr(ADDR_CTRL_A, 8'h10);
      settle(4);
      for (int i = 0; i < 4; i++) begin
         m = 8'(i);
         wr(ADDR_CTRL_A, 8'h10 | m);
         drive_pos(200);
         rdc(ADDR_CTRL_A, 8'h20 | m | ((i == 0 || i == 3) ? 8'h10 : 8'h00),
            "rise");
         wr(ADDR_CTRL_A, 8'h10 | m);
         drive_pos(0);
         rdc(ADDR_CTRL_A, m | ((i == 0 || i == 2) ? 8'h10 : 8'h00),
            "fall");
      end
   endtask
   task t_irq;
      wr(ADDR_CTRL_A, 8'h13);
      @(posedge pclk);
      gie <= 1;
      wr(ADDR_CTRL_A, 8'h0B);
      drive_pos(200);
      cmp1("irq on", 1, irq);
      wr(ADDR_CTRL_A, 8'h0B);
      rdc(ADDR_CTRL_A, 8'h3B, "write zero");
      gie <= 0;
      settle(2);
      cmp1("irq gated", 0, irq);
      @(posedge pclk);
      gie <= 1;
      ack_on <= 1;
      settle(5);
      cmp1("irq acked", 0, irq);
      rdc(ADDR_CTRL_A, 8'h2B, "vector clear");
      ack_on <= 0;
      drive_pos(0);
   endtask
   task t_route;
      wr(ADDR_CTRL_A, 8'h04);
      drive_pos(200);
      cmp1("route", 1, route);
      cmp1("trigger", 1, trig);
      cmp1("result", 1, res);
      wr(ADDR_CTRL_A, 8'h00);
      settle(2);
      cmp1("no trigger", 0, trig);
      @(posedge pclk);
      clk_en <= 0;
      pos_mv <= 0;
      settle(4);
      cmp1("frozen", 1, res);
      @(posedge pclk);
      clk_en <= 1;
      settle(4);
      cmp1("thawed", 0, res);
   endtask
   task t_mux;
      for (int c = 0; c < 8; c++) begin
         @(posedge pclk);
         chan <= 4'(c);
         settle(2);
         cmp1("mux on", 1, mux_act);
         cmp8("channel", 8'(c), {5'b0, neg_ch});
      end
      @(posedge pclk);
      chan <= 4'h9;
      settle(2);
      cmp1("code 9", 0, mux_act);
      @(posedge pclk);
      chan <= 4'h7;
      conv <= 1;
      settle(2);
      cmp1("conv on", 0, mux_act);
      @(posedge pclk);
      conv <= 0;
      wr(ADDR_CTRL_B, 8'h00);
      settle(2);
      cmp1("mux off", 0, mux_act);
   endtask
   task t_pins;
      @(posedge pclk);
      pins <= 8'hA6;
      wr(ADDR_INPUT_DISABLE, 8'h06);
      rdc(ADDR_INPUT_DISABLE, 8'h06, "disable rb");
      settle(3);
      cmp8("buffer off", 8'h06, buf_off);
      cmp8("pins masked", 8'hA0, pin_rd);
      wr(ADDR_INPUT_DISABLE, 8'h00);
      settle(3);
      cmp8("pins open", 8'hA6, pin_rd);
   endtask
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1;
      t_reset();
      t_ctrl();
      t_modes();
      t_irq();
      t_route();
      t_mux();
      t_pins();
      stop_test();
   end
endmodule
